// *** shared/mcf_pkg.sv ***
// Constants and types for the motion command frame interpreter.
// Assumes one 100 MHz system clock shared by every user of this package.
package mcf_pkg;

   // Timing
   localparam int          CLK_FREQ_MHZ       = 100;
   localparam int          GAP_TIMEOUT_US     = 1000;
   localparam int          GAP_TIMEOUT_CYCLES = GAP_TIMEOUT_US * CLK_FREQ_MHZ;

   // Frame layout
   localparam logic [3:0]  FRAME_LEN_SERIAL   = 4'h9;
   localparam logic [3:0]  FRAME_LEN_CAN      = 4'h7;
   localparam logic [3:0]  CORE_LEN           = 4'h7;
   localparam logic [3:0]  POS_ADDR           = 4'h0;
   localparam int          VALUE_BYTES        = 4;

   // Reply status codes
   localparam logic [7:0]  STAT_OK            = 8'h64;
   localparam logic [7:0]  STAT_STORED        = 8'h65;
   localparam logic [7:0]  STAT_BAD_SUM       = 8'h01;
   localparam logic [7:0]  STAT_BAD_CMD       = 8'h02;
   localparam logic [7:0]  STAT_BAD_TYPE      = 8'h03;
   localparam logic [7:0]  STAT_BAD_VALUE     = 8'h04;
   localparam logic [7:0]  STAT_LOCKED        = 8'h05;
   localparam logic [7:0]  STAT_UNAVAIL       = 8'h06;

   // Default depth of the stored program
   localparam int          PROG_DEPTH         = 16;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [7:0]  kind;
      logic [7:0]  bank;
      logic [31:0] value;
   } mcf_cmd_t;

   typedef struct packed {
      logic [7:0]  status;
      logic [7:0]  cmd;
      logic [31:0] value;
   } mcf_reply_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_EXEC,
      S_REPLY
   } mcf_state_t;

   // Modulo-256 addition used by both checksum paths
   function automatic logic [7:0] mcf_add8(input logic [7:0] a, input logic [7:0] b);
      return 8'(a + b);
   endfunction

endpackage

// *** rtl/mcf_reply_tx.sv ***
// Reply serializer: turns one reply record into a byte stream.
// Assumes a byte transmitter on the same clock with a valid/ready handshake.
module mcf_reply_tx (
   input  wire  logic              clk_sys_in,
   input  wire  logic              reset_in,
   input  wire  logic              start_in,
   input  wire  logic              can_in,
   input  wire  logic [7:0]        reply_addr_in,
   input  wire  logic [7:0]        module_addr_in,
   input  wire  mcf_pkg::mcf_reply_t reply_in,
   output logic                    tx_valid_out,
   output logic [7:0]              tx_byte_out,
   input  wire  logic              tx_ready_in,
   output logic                    busy_out,
   output logic                    done_out
);
   import mcf_pkg::*;

   logic [71:0] shreg;
   logic [3:0]  left;
   logic [63:0] body;
   logic [7:0]  sum;
   logic        take;

   ////////////////////////////////////////////////////////////////////////
   // Frame image and checksum
   always_comb begin
      body = {reply_addr_in, module_addr_in, reply_in.status, reply_in.cmd,
              reply_in.value};
      sum  = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sum = mcf_add8(sum, body[i*8 +: 8]);
      end
   end

   assign take         = busy_out && tx_ready_in;
   assign tx_valid_out = busy_out;
   assign tx_byte_out  = shreg[71:64];

   ////////////////////////////////////////////////////////////////////////
   // Shift out
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         shreg    <= '0;
         left     <= '0;
         busy_out <= 1'b0;
      end else if (start_in && !busy_out) begin
         busy_out <= 1'b1;
         if (can_in) begin
            shreg <= {body[55:0], 16'h0000};
            left  <= FRAME_LEN_CAN;
         end else begin
            shreg <= {body, sum};
            left  <= FRAME_LEN_SERIAL;
         end
      end else if (take) begin
         shreg <= {shreg[63:0], 8'h00};
         left  <= 4'(left - 4'h1);
         if (left == 4'h1) begin
            busy_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= take && (left == 4'h1);
      end
   end

endmodule

// *** rtl/mcf_frame_interp.sv ***
// Command frame interpreter: receives framed binary commands, checks them,
// hands them to the executor, stores or replays a program, and answers.
// Assumes rx bytes and tx handshake come from a UART or CAN core on clk_sys_in.
//
// How it works
// - Transmit only while answering a received command; otherwise stay listening.
// - Reply to an executed command goes out only after it has finished executing.
// - Command core is command, type, motor or bank, four value bytes.
// - Serial frames are nine bytes: address, seven core bytes, checksum.
// - Order: address, command, type, bank, value MSB first, checksum.
// - Checksum is the 8-bit sum of all prior bytes, address included.
// - On CAN the frame has no address and no checksum byte.
// - Every accepted command gets exactly one reply.
// - Reply: reply address, module address, status, command, value, checksum.
// - Reply checksum is the 8-bit sum of the other reply bytes.
// - CAN reply drops reply address and checksum bytes.
// - Status codes 100, 101, 1 to 6 as defined in the package.
// - Commands may be stored as a program and later run without host.
module mcf_frame_interp #(
   parameter int GAP_CYCLES = mcf_pkg::GAP_TIMEOUT_CYCLES,
   parameter int DEPTH      = mcf_pkg::PROG_DEPTH
) (
   input  wire  logic              clk_sys_in,
   input  wire  logic              reset_in,
   input  wire  logic              link_can_in,
   input  wire  logic [7:0]        module_addr_in,
   input  wire  logic [7:0]        reply_addr_in,
   input  wire  logic              rx_valid_in,
   input  wire  logic [7:0]        rx_byte_in,
   output logic                    tx_valid_out,
   output logic [7:0]              tx_byte_out,
   input  wire  logic              tx_ready_in,
   output logic                    tx_drive_out,
   input  wire  logic              prog_load_in,
   input  wire  logic              prog_run_in,
   output logic                    exec_valid_out,
   output mcf_pkg::mcf_cmd_t       exec_cmd_out,
   output logic                    exec_from_prog_out,
   input  wire  logic              exec_done_in,
   input  wire  logic [7:0]        exec_status_in,
   input  wire  logic [31:0]       exec_value_in,
   output logic                    run_active_out,
   output logic [7:0]              prog_len_out,
   output logic                    frame_drop_out
);
   import mcf_pkg::*;

   localparam logic [7:0] DEPTH_B = 8'(DEPTH);

   mcf_state_t  state;
   logic [3:0]  rx_idx;
   logic [7:0]  rx_sum;
   logic        addr_match;
   logic [7:0]  core [0:6];
   logic [31:0] gap_cnt;
   logic [3:0]  frame_len;
   logic        rx_take;
   logic        rx_last;
   logic        gap_hit;
   logic        pend;
   logic        pend_bad;
   mcf_cmd_t    pend_cmd;
   mcf_cmd_t    next_cmd;
   mcf_cmd_t    prog_mem [0:DEPTH-1];
   logic [7:0]  pc;
   logic        load_prev;
   logic        run_prev;
   logic        take_frame;
   logic        store_ok;
   mcf_reply_t  reply;
   logic        tx_start;
   logic        tx_busy;
   logic        tx_done;

   ////////////////////////////////////////////////////////////////////////
   // Receive framing
   assign frame_len = link_can_in ? FRAME_LEN_CAN : FRAME_LEN_SERIAL;
   assign rx_take   = rx_valid_in && !pend;
   assign rx_last   = rx_take && (rx_idx == 4'(frame_len - 4'h1));
   assign gap_hit   = (rx_idx != 4'h0) && !rx_valid_in
                      && (gap_cnt == 32'(GAP_CYCLES - 1));

   always_comb begin
      if (link_can_in) begin
         next_cmd = {core[0], core[1], core[2], core[3], core[4], core[5],
                     rx_byte_in};
      end else begin
         next_cmd = {core[0], core[1], core[2], core[3], core[4], core[5],
                     core[6]};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rx_idx     <= '0;
         rx_sum     <= '0;
         addr_match <= 1'b0;
      end else if (rx_take) begin
         rx_idx <= rx_last ? 4'h0 : 4'(rx_idx + 4'h1);
         rx_sum <= (rx_idx == 4'h0) ? rx_byte_in : mcf_add8(rx_sum, rx_byte_in);
         if (!link_can_in && rx_idx == POS_ADDR) begin
            addr_match <= (rx_byte_in == module_addr_in);
         end
      end else if (gap_hit) begin
         rx_idx <= '0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         for (int i = 0; i < 7; i++) begin
            core[i] <= '0;
         end
      end else if (rx_take) begin
         if (link_can_in) begin
            if (rx_idx < CORE_LEN) begin
               core[3'(rx_idx)] <= rx_byte_in;
            end
         end else if (rx_idx != POS_ADDR && rx_idx <= CORE_LEN) begin
            core[3'(rx_idx - 4'h1)] <= rx_byte_in;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in || rx_take || rx_idx == 4'h0) begin
         gap_cnt <= '0;
      end else if (!gap_hit) begin
         gap_cnt <= 32'(gap_cnt + 32'd1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         frame_drop_out <= 1'b0;
      end else begin
         frame_drop_out <= gap_hit || (rx_last && !link_can_in && !addr_match);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending frame handed to the dispatcher
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pend     <= 1'b0;
         pend_bad <= 1'b0;
         pend_cmd <= '0;
      end else if (rx_last && (link_can_in || addr_match)) begin
         pend     <= 1'b1;
         pend_bad <= !link_can_in && (rx_byte_in != rx_sum);
         pend_cmd <= next_cmd;
      end else if (take_frame) begin
         pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program memory
   assign take_frame = (state == S_IDLE) && pend;
   assign store_ok   = prog_len_out < DEPTH_B;

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         load_prev <= 1'b0;
         run_prev  <= 1'b0;
      end else begin
         load_prev <= prog_load_in;
         run_prev  <= prog_run_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         prog_len_out <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            prog_mem[i] <= '0;
         end
      end else if (prog_load_in && !load_prev) begin
         prog_len_out <= '0;
      end else if (take_frame && !pend_bad && prog_load_in && store_ok) begin
         prog_mem[prog_len_out[$clog2(DEPTH)-1:0]] <= pend_cmd;
         prog_len_out <= 8'(prog_len_out + 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dispatch, execution and reply sequencing
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state              <= S_IDLE;
         exec_valid_out     <= 1'b0;
         exec_cmd_out       <= '0;
         exec_from_prog_out <= 1'b0;
         reply              <= '0;
         tx_start           <= 1'b0;
         run_active_out     <= 1'b0;
         pc                 <= '0;
      end else begin
         exec_valid_out <= 1'b0;
         tx_start       <= 1'b0;
         if (prog_run_in && !run_prev && prog_len_out != 8'h00 && !prog_load_in) begin
            run_active_out <= 1'b1;
            pc             <= '0;
         end else if (!prog_run_in) begin
            run_active_out <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (pend) begin
                  if (pend_bad) begin
                     reply    <= {STAT_BAD_SUM, pend_cmd.cmd, 32'h0000_0000};
                     tx_start <= 1'b1;
                     state    <= S_REPLY;
                  end else if (prog_load_in) begin
                     reply    <= {store_ok ? STAT_STORED : STAT_UNAVAIL,
                                  pend_cmd.cmd, pend_cmd.value};
                     tx_start <= 1'b1;
                     state    <= S_REPLY;
                  end else begin
                     exec_valid_out     <= 1'b1;
                     exec_cmd_out       <= pend_cmd;
                     exec_from_prog_out <= 1'b0;
                     state              <= S_EXEC;
                  end
               end else if (run_active_out && prog_run_in) begin
                  exec_valid_out     <= 1'b1;
                  exec_cmd_out       <= prog_mem[pc[$clog2(DEPTH)-1:0]];
                  exec_from_prog_out <= 1'b1;
                  state              <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (exec_done_in) begin
                  if (exec_from_prog_out) begin
                     pc    <= 8'(pc + 8'h01);
                     state <= S_IDLE;
                     if (8'(pc + 8'h01) >= prog_len_out) begin
                        run_active_out <= 1'b0;
                     end
                  end else begin
                     reply    <= {exec_status_in, exec_cmd_out.cmd,
                                  exec_value_in};
                     tx_start <= 1'b1;
                     state    <= S_REPLY;
                  end
               end
            end
            S_REPLY: begin
               if (tx_done) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reply transmitter
   assign tx_drive_out = tx_busy;

   mcf_reply_tx u_reply_tx (
      .clk_sys_in     (clk_sys_in),
      .reset_in       (reset_in),
      .start_in       (tx_start),
      .can_in         (link_can_in),
      .reply_addr_in  (reply_addr_in),
      .module_addr_in (module_addr_in),
      .reply_in       (reply),
      .tx_valid_out   (tx_valid_out),
      .tx_byte_out    (tx_byte_out),
      .tx_ready_in    (tx_ready_in),
      .busy_out       (tx_busy),
      .done_out       (tx_done)
   );

endmodule

// *** tb/mcf_frame_interp_asserts.sv ***
// Port checker for the command frame interpreter.
// Assumes one clock domain and the synchronous active-high reset of the top module.
module mcf_frame_interp_asserts (
   input wire logic       clk_sys_in,
   input wire logic       reset_in,
   input wire logic       link_can_in,
   input wire logic [7:0] module_addr_in,
   input wire logic [7:0] reply_addr_in,
   input wire logic       tx_valid_out,
   input wire logic [7:0] tx_byte_out,
   input wire logic       tx_ready_in,
   input wire logic       tx_drive_out,
   input wire logic       exec_valid_out,
   input wire logic       exec_from_prog_out,
   input wire logic       exec_done_in,
   input wire logic       run_active_out,
   input wire logic       frame_drop_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import mcf_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   logic [3:0] cnt;
   logic [7:0] sum;
   ////////////////////////////////////////////////////////////////////////////////
   // Accepted reply bytes and their running sum
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || !tx_drive_out) begin
         cnt <= 4'h0;
         sum <= 8'h00;
      end else if (tx_valid_out && tx_ready_in) begin
         cnt <= cnt + 4'h1;
         sum <= sum + tx_byte_out;
      end
   end
   sequence s_take;
      tx_valid_out && tx_ready_in;
   endsequence
   sequence s_start;
      $rose(tx_valid_out);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_tx_drive_on: assert property (tx_valid_out |-> tx_drive_out)
      else $error("reply byte offered while driver disabled");
   chk_exec_one_cycle: assert property (exec_valid_out |=> !exec_valid_out)
      else $error("execute strobe longer than one cycle");
   chk_reply_after_exec: assert property (
      exec_done_in && !exec_from_prog_out && !run_active_out |-> ##2 tx_valid_out)
      else $error("no reply after execution finished");
   chk_byte_holds: assert property (
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
      else $error("reply byte changed before acceptance");
   chk_first_serial: assert property (s_start ##0 !link_can_in |-> tx_byte_out == reply_addr_in)
      else $error("serial reply does not start with reply address");
   chk_first_can: assert property (s_start ##0 link_can_in |-> tx_byte_out == module_addr_in)
      else $error("link reply does not start with module address");
   chk_reply_length: assert property (
      $fell(tx_drive_out) |-> cnt == (link_can_in ? 4'h7 : 4'h9))
      else $error("wrong reply length");
   chk_reply_sum: assert property (
      (!link_can_in && cnt == 4'h8) ##0 s_take |-> tx_byte_out == sum)
      else $error("wrong reply checksum");
   chk_drop_silent: assert property (frame_drop_out |-> !tx_valid_out [*4])
      else $error("reply sent for dropped frame");
   chk_no_cmd_midreply: assert property (
      exec_valid_out && !exec_from_prog_out |-> !tx_drive_out)
      else $error("command issued during reply");
endmodule

bind mcf_frame_interp mcf_frame_interp_asserts mcf_frame_interp_asserts_i (.clk_sys_in,
   .reset_in, .link_can_in, .module_addr_in, .reply_addr_in, .tx_valid_out, .tx_byte_out,
   .tx_ready_in, .tx_drive_out, .exec_valid_out, .exec_from_prog_out, .exec_done_in,
   .run_active_out, .frame_drop_out);

// *** tb/mcf_host_model.sv ***
// Host model: sends command frames and collects reply bytes.
// Assumes the interpreter's byte-level receive and transmit handshakes.
module mcf_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            rx_valid_out,
   output logic [7:0]      rx_byte_out,
   output logic            tx_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import mcf_pkg::*;
   logic [7:0] rq[$];
   int         stall = 0;
   int         cyc = 0;
   initial begin
      rx_valid_out = 1'b0;
      rx_byte_out = 8'h00;
      tx_ready_out = 1'b0;
   end
   // Slow host takes a byte only every stall cycles
   always @(negedge clk_sys_in) begin
      cyc <= cyc + 1;
      tx_ready_out <= (stall == 0) || (cyc % stall == 0);
   end
   always @(posedge clk_sys_in) begin
      if (tx_valid_in && tx_ready_out) rq.push_back(tx_byte_in);
   end
   // Sends the first n bytes; bad is xored into the checksum
   task automatic send_frame(input logic [7:0] addr, input mcf_cmd_t c, input logic [7:0] bad,
                             input bit can, input int n);
      logic [7:0] f[$];
      logic [7:0] s;
      f = {c.cmd, c.kind, c.bank, c.value[31:24], c.value[23:16], c.value[15:8],
           c.value[7:0]};
      if (!can) begin
         f.push_front(addr);
         s = 8'h00;
         foreach (f[i]) s += f[i];
         f.push_back(s ^ bad);
      end
      for (int i = 0; i < n && i < f.size(); i++) begin
         @(negedge clk_sys_in);
         rx_valid_out <= 1'b1;
         rx_byte_out <= f[i];
         @(negedge clk_sys_in);
         rx_valid_out <= 1'b0;
         rx_byte_out <= ~f[i];
      end
   endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the command frame interpreter.
// Assumes the host model on the link side and a small executor model here.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mcf_pkg::*;
   localparam int         GAP = 50;
   localparam logic [7:0] MOD = 8'hFE;
   logic        clk_sys_in = 1'b0, reset_in = 1'b1, link_can_in = 1'b0;
   logic [7:0]  module_addr_in = MOD, reply_addr_in = 8'h02, rx_byte_in, tx_byte_out;
   logic        rx_valid_in, tx_valid_out, tx_ready_in, tx_drive_out, exec_valid_out;
   logic        prog_load_in = 1'b0, prog_run_in = 1'b0, exec_done_in = 1'b0;
   logic        exec_from_prog_out, run_active_out, frame_drop_out, last_prog;
   logic [7:0]  exec_status_in = 8'h00, prog_len_out;
   logic [31:0] exec_value_in = 32'h0000_0000;
   mcf_cmd_t    exec_cmd_out, last_cmd;
   int          ex_lat = 1, wt = 0, execs = 0, drops = 0, fail_count = 0;
   int          total_checks = 0, cycles = 0;
   mcf_frame_interp #(.GAP_CYCLES(GAP)) mcf_frame_interp_i (.clk_sys_in, .reset_in,
      .link_can_in, .module_addr_in, .reply_addr_in, .rx_valid_in, .rx_byte_in, .tx_valid_out,
      .tx_byte_out, .tx_ready_in, .tx_drive_out, .prog_load_in, .prog_run_in, .exec_valid_out,
      .exec_cmd_out, .exec_from_prog_out, .exec_done_in, .exec_status_in, .exec_value_in,
      .run_active_out, .prog_len_out, .frame_drop_out);
   mcf_host_model host_i (.clk_sys_in, .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
      .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .tx_ready_out(tx_ready_in));
   always #5 clk_sys_in = ~clk_sys_in;
   ////////////////////////////////////////////////////////////////////////////////
   // Executor answers ex_lat cycles after each issue
   always @(negedge clk_sys_in) begin : exec_model
      bit fire;
      fire = 1'b0;
      if (exec_valid_out === 1'b1) wt = ex_lat;
      else if (wt > 0) begin
         wt = wt - 1;
         fire = (wt == 0);
      end
      exec_done_in <= fire;
   end
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (frame_drop_out === 1'b1) drops <= drops + 1;
      if (exec_valid_out === 1'b1) begin
         execs <= execs + 1;
         last_cmd <= exec_cmd_out;
         last_prog <= exec_from_prog_out;
      end
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check_reply(input logic [7:0] st, input logic [7:0] cmd, input logic [31:0] v);
      logic [7:0] e[$];
      logic [7:0] s;
      e = {reply_addr_in, MOD, st, cmd, v[31:24], v[23:16], v[15:8], v[7:0]};
      if (link_can_in) e = e[1:7];
      else begin
         s = 8'h00;
         foreach (e[i]) s += e[i];
         e.push_back(s);
      end
      for (int i = 0; i < 900 && host_i.rq.size() < e.size(); i++) @(posedge clk_sys_in);
      repeat (4) @(posedge clk_sys_in);
      `CHK(host_i.rq.size(), e.size())
      foreach (e[i]) `CHK(host_i.rq[i], e[i])
      host_i.rq.delete();
   endtask
   task automatic t_direct();
      logic [7:0] st[6] = '{STAT_OK, STAT_BAD_CMD, STAT_BAD_TYPE, STAT_BAD_VALUE, STAT_LOCKED,
                            STAT_UNAVAIL};
      mcf_cmd_t   c;
      int         e0;
      for (int i = 0; i < 6; i++) begin
         c = '{8'h05 + 8'(i), 8'h80, 8'hFF, 32'hF000_00A5 + 32'(i)};
         @(negedge clk_sys_in);
         exec_status_in = st[i];
         exec_value_in = c.value ^ 32'hFFFF_0000;
         host_i.stall = i % 3;
         ex_lat = 1 + i * 7;
         e0 = execs;
         host_i.send_frame(MOD, c, 8'h00, 1'b0, 9);
         check_reply(st[i], c.cmd, exec_value_in);
         `CHK(execs, e0 + 1)
         `CHK(last_cmd, c)
      end
   endtask
   task automatic t_faults();
      mcf_cmd_t c = '{8'h06, 8'h01, 8'h00, 32'h0000_0010};
      int       e0;
      int       d0;
      e0 = execs;
      d0 = drops;
      host_i.send_frame(MOD, c, 8'h01, 1'b0, 9);
      check_reply(STAT_BAD_SUM, c.cmd, 32'h0000_0000);
      host_i.send_frame(MOD ^ 8'h01, c, 8'h00, 1'b0, 9);
      repeat (40) @(posedge clk_sys_in);
      `CHK(host_i.rq.size(), 0)
      `CHK(drops, d0 + 1)
      host_i.send_frame(MOD, c, 8'h00, 1'b0, 4);
      repeat (GAP + 10) @(posedge clk_sys_in);
      `CHK(drops, d0 + 2)
      `CHK(execs, e0)
      @(negedge clk_sys_in);
      exec_status_in = STAT_OK;
      host_i.send_frame(MOD, c, 8'h00, 1'b0, 9);
      check_reply(STAT_OK, c.cmd, exec_value_in);
   endtask
   task automatic t_can();
      mcf_cmd_t c = '{8'h0A, 8'h02, 8'h01, 32'h8765_4321};
      @(negedge clk_sys_in);
      link_can_in = 1'b1;
      host_i.send_frame(MOD, c, 8'h00, 1'b1, 7);
      check_reply(STAT_OK, c.cmd, exec_value_in);
      `CHK(last_cmd, c)
      @(negedge clk_sys_in);
      link_can_in = 1'b0;
   endtask
   task automatic t_store();
      mcf_cmd_t c = '{8'h04, 8'h01, 8'h00, 32'h0001_0000};
      int       e0;
      e0 = execs;
      @(negedge clk_sys_in);
      prog_load_in = 1'b1;
      for (int i = 0; i < 2; i++) begin
         host_i.send_frame(MOD, c, 8'h00, 1'b0, 9);
         check_reply(STAT_STORED, c.cmd, c.value);
      end
      `CHK(prog_len_out, 8'h02)
      `CHK(execs, e0)
      @(negedge clk_sys_in);
      prog_load_in = 1'b0;
      @(negedge clk_sys_in);
      prog_run_in = 1'b1;
      ex_lat = 3;
      for (int i = 0; i < 300 && (execs < e0 + 2 || run_active_out !== 1'b0); i++)
         @(posedge clk_sys_in);
      `CHK(execs, e0 + 2)
      `CHK(last_prog, 1'b1)
      `CHK(host_i.rq.size(), 0)
      @(negedge clk_sys_in);
      prog_run_in = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      reset_in = 1'b0;
      t_direct();
      t_faults();
      t_can();
      t_store();
      test_done();
   end
endmodule
